// ===== hw/rta_channel_cfg.sv
// Channel interrupt and equalizer adaptation configuration slice.
// Holds the control, eye threshold and handoff registers, the sticky
// interrupt status, and the sequencer driving CTLE and DFE adaptation.
// Assumes an 8-bit register port on the system clock, analog lock and
// signal-detect levels from another domain, and engines on this clock.
//
// Notes on behaviour
// - PRBS error enable lets checker errors interrupt
// - Select 00 stops adaptation, 01 CTLE only
// - Select 10: CTLE, DFE, then CTLE again
// - Select 11: CTLE to lock, DFE, EQ
// - Merit 00/11 both, 01 horizontal, 10 vertical
// - Alternate merit input overrides merit select
// - Lock-loss enable gates CDR lock-loss interrupt
// - Signal-detect-loss enable gates loss interrupt
// - Eye interrupt levels: horizontal high, vertical low
// - One level step equals eight eye counts
// - Mode three waits for minimum eye before DFE
// - Handoff minimums are four-bit nibbles, max 15
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module rta_channel_cfg #(
  parameter int EYE_W = rta_pkg::EYE_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Analog levels from outside this clock domain
  input wire logic i_cdr_lock,
  input wire logic i_sigdet,
  // Same-clock sources
  input wire logic i_prbs_err,
  input wire logic i_eye_valid,
  input wire rta_pkg::rta_eye_s i_eye,
  input wire logic i_alt_merit,
  input wire logic i_adapt_restart,
  input wire logic i_ctle_optimal,
  input wire logic i_dfe_done,
  // Engine controls and interrupt
  output rta_pkg::rta_eq_ctl_s o_eq_ctl,
  output logic o_irq
);

  // All state of this slice except the synchroniser and eye checkers
  typedef struct packed {
    logic [7:0] ctrl; // Enables, mode, merit
    logic [7:0] thr; // Eye interrupt levels
    logic [7:0] emin; // Eye minimum for DFE handoff
    logic [7:0] eye_en; // Eye interrupt enable
    logic [7:0] status; // Sticky events
    logic [7:0] rdata; // Read data, one cycle
    logic lock_prev; // Edge memory for lock
    logic sigdet_prev; // Edge memory for signal detect
    logic eye_low_prev; // Edge memory for eye closure
    rta_pkg::rta_state_e state; // Sequencer
    logic ctle_en; // CTLE adapt enable out
    logic dfe_en; // DFE adapt enable out
    rta_pkg::rta_merit_e merit; // Merit out
  } rta_core_st_s;

  localparam rta_core_st_s CORE_RESET = '{
    ctrl: rta_pkg::RST_IRQ_ADAPT_CTRL,
    thr: rta_pkg::RST_EYE_IRQ_THR,
    emin: rta_pkg::RST_EYE_MIN_DFE,
    eye_en: rta_pkg::RST_EYE_IRQ_EN,
    status: rta_pkg::RST_ZERO,
    rdata: rta_pkg::RST_ZERO,
    lock_prev: 1'b0,
    sigdet_prev: 1'b0,
    eye_low_prev: 1'b0,
    state: rta_pkg::ST_IDLE,
    ctle_en: 1'b0,
    dfe_en: 1'b0,
    merit: rta_pkg::MERIT_BOTH
  };

  rta_core_st_s q;
  rta_core_st_s d;

  // Synchronised analog levels
  logic [1:0] pins_async;
  logic [1:0] pins_level;
  logic lock_s; // CDR lock, filtered
  logic sigdet_s; // Signal present, filtered

  // Eye comparison results
  logic h_below;
  logic v_below;
  logic h_meets;
  logic v_meets;
  logic eye_low;
  logic eye_ok;

  // Decoded fields
  rta_pkg::rta_mode_e mode;
  logic [1:0] merit_sel;
  logic [7:0] irq_mask;
  logic [7:0] events;
  logic [7:0] w1c;
  logic [7:0] live;
  logic [7:0] rd_mux;
  logic wr_ctrl;

  assign pins_async = {i_cdr_lock, i_sigdet};

  // Lock and signal detect come from the analog front end
  rta_pin_sync #(
    .W(2)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(pins_async),
    .o_level(pins_level)
  );

  assign lock_s = pins_level[1];
  assign sigdet_s = pins_level[0];

  // Horizontal opening against the high nibbles
  rta_eye_check #(
    .EYE_W(EYE_W)
  ) u_eye_horiz (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_valid(i_eye_valid),
    .i_eye(i_eye.horiz),
    .i_irq_level(q.thr[rta_pkg::HORIZ_LSB +: rta_pkg::LEVEL_W]),
    .i_min_level(q.emin[rta_pkg::HORIZ_LSB +: rta_pkg::LEVEL_W]),
    .o_below_irq(h_below),
    .o_meets_min(h_meets)
  );

  // Vertical opening against the low nibbles
  rta_eye_check #(
    .EYE_W(EYE_W)
  ) u_eye_vert (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_valid(i_eye_valid),
    .i_eye(i_eye.vert),
    .i_irq_level(q.thr[rta_pkg::VERT_LSB +: rta_pkg::LEVEL_W]),
    .i_min_level(q.emin[rta_pkg::VERT_LSB +: rta_pkg::LEVEL_W]),
    .o_below_irq(v_below),
    .o_meets_min(v_meets)
  );

  // Either direction closing is one eye event
  assign eye_low = h_below | v_below;
  // Handoff needs both directions open enough
  assign eye_ok = h_meets & v_meets;

  assign mode = rta_pkg::rta_mode_e'(q.ctrl[rta_pkg::MODE_LSB +: 2]);
  assign merit_sel = q.ctrl[rta_pkg::MERIT_LSB +: 2];
  assign wr_ctrl = i_wr && (i_addr == rta_pkg::ADDR_IRQ_ADAPT_CTRL);

  // Event pulses, same layout as the status register
  always_comb begin
    events = '0;
    events[rta_pkg::STAT_PRBS] = i_prbs_err;
    events[rta_pkg::STAT_EYE] = eye_low & ~q.eye_low_prev;
    events[rta_pkg::STAT_LOCK] = q.lock_prev & ~lock_s;
    events[rta_pkg::STAT_SIGDET] = q.sigdet_prev & ~sigdet_s;
  end

  // Mask built from the enables, same layout as status
  always_comb begin
    irq_mask = '0;
    // PRBS error enable
    irq_mask[rta_pkg::STAT_PRBS] = q.ctrl[rta_pkg::BIT_PRBS_EN];
    // Eye enable lives in its own register
    irq_mask[rta_pkg::STAT_EYE] = q.eye_en[rta_pkg::STAT_EYE];
    // Lock-loss enable
    irq_mask[rta_pkg::STAT_LOCK] = q.ctrl[rta_pkg::BIT_LOCK_EN];
    // Signal-detect-loss enable
    irq_mask[rta_pkg::STAT_SIGDET] = q.ctrl[rta_pkg::BIT_SIGDET_EN];
  end

  // Write-one-to-clear strobe for the status register
  always_comb begin
    w1c = '0;
    if (i_wr && (i_addr == rta_pkg::ADDR_IRQ_STATUS)) begin
      w1c = i_wdata;
    end
  end

  // Live view of the channel, read only
  always_comb begin
    live = '0;
    live[0] = sigdet_s;
    live[1] = lock_s;
    live[2] = eye_low;
    live[3] = eye_ok;
    live[6:4] = q.state;
    live[7] = (q.state == rta_pkg::ST_DONE);
  end

  // Read decode; unmapped offsets answer zero
  always_comb begin
    unique case (i_addr)
      rta_pkg::ADDR_IRQ_ADAPT_CTRL: rd_mux = q.ctrl;
      rta_pkg::ADDR_EYE_IRQ_THR: rd_mux = q.thr;
      rta_pkg::ADDR_EYE_MIN_DFE: rd_mux = q.emin;
      // Status stays readable whatever the enables
      rta_pkg::ADDR_IRQ_STATUS: rd_mux = q.status;
      rta_pkg::ADDR_EYE_IRQ_EN: rd_mux = q.eye_en;
      rta_pkg::ADDR_LIVE_STATUS: rd_mux = live;
      default: rd_mux = '0;
    endcase
  end

  // Next state of the whole slice except the synchroniser and eye checkers
  always_comb begin
    d = q;

    // Read data stands one cycle only
    d.rdata = i_rd ? rd_mux : '0;

    // Register writes; reserved control bit stays zero
    if (wr_ctrl) begin
      d.ctrl = i_wdata & rta_pkg::CTRL_WR_MASK;
    end
    if (i_wr && (i_addr == rta_pkg::ADDR_EYE_IRQ_THR)) begin
      d.thr = i_wdata;
    end
    if (i_wr && (i_addr == rta_pkg::ADDR_EYE_MIN_DFE)) begin
      d.emin = i_wdata;
    end
    if (i_wr && (i_addr == rta_pkg::ADDR_EYE_IRQ_EN)) begin
      d.eye_en = i_wdata & rta_pkg::EYE_EN_MASK;
    end

    // Set wins over clear so no event slips past a clear
    d.status = ((q.status & ~w1c) | events) & rta_pkg::STAT_USED_MASK;

    // Edge memories
    d.lock_prev = lock_s;
    d.sigdet_prev = sigdet_s;
    d.eye_low_prev = eye_low;

    // Sequencer; restart starts over, a control write starts it only from idle or done
    unique case (q.state)
      rta_pkg::ST_IDLE,
      rta_pkg::ST_DONE: begin
        if (i_adapt_restart || wr_ctrl) begin
          d.state = rta_pkg::ST_CTLE_FIRST;
        end
      end
      rta_pkg::ST_CTLE_FIRST: begin
        if (i_adapt_restart) begin
          d.state = rta_pkg::ST_CTLE_FIRST;
        end else if (mode == rta_pkg::ADAPT_CTLE_ONLY) begin
          // CTLE alone, finished when optimal
          if (i_ctle_optimal) begin
            d.state = rta_pkg::ST_DONE;
          end
        end else if (mode == rta_pkg::ADAPT_CTLE_DFE_CTLE) begin
          // CTLE to optimum before DFE
          if (i_ctle_optimal) begin
            d.state = rta_pkg::ST_DFE;
          end
        end else if (lock_s && eye_ok) begin
          // Lock plus minimum eye before DFE
          d.state = rta_pkg::ST_DFE;
        end
      end
      rta_pkg::ST_DFE: begin
        // DFE relies on the host having powered it up
        if (i_adapt_restart) begin
          d.state = rta_pkg::ST_CTLE_FIRST;
        end else if (i_dfe_done) begin
          d.state = rta_pkg::ST_CTLE_FINAL;
        end
      end
      rta_pkg::ST_CTLE_FINAL: begin
        // Final equalizer pass until optimal
        if (i_adapt_restart) begin
          d.state = rta_pkg::ST_CTLE_FIRST;
        end else if (i_ctle_optimal) begin
          d.state = rta_pkg::ST_DONE;
        end
      end
      // Unused codes recover to idle
      default: d.state = rta_pkg::ST_IDLE;
    endcase

    // No adaptation in mode zero; the incoming value counts so that
    // a write of mode zero never starts a one-cycle pass
    if (rta_pkg::rta_mode_e'(d.ctrl[rta_pkg::MODE_LSB +: 2]) ==
        rta_pkg::ADAPT_NONE) begin
      d.state = rta_pkg::ST_IDLE;
    end

    // Engine enables follow the next state
    d.ctle_en = (d.state == rta_pkg::ST_CTLE_FIRST) ||
                (d.state == rta_pkg::ST_CTLE_FINAL);
    d.dfe_en = (d.state == rta_pkg::ST_DFE);

    // Figure of merit; alternate input has precedence
    if (i_alt_merit) begin
      d.merit = rta_pkg::MERIT_ALT;
    end else begin
      // Both directions for 00 and 11
      unique case (merit_sel)
        2'h1: d.merit = rta_pkg::MERIT_HORIZ;
        2'h2: d.merit = rta_pkg::MERIT_VERT;
        2'h0,
        2'h3: d.merit = rta_pkg::MERIT_BOTH;
      endcase
    end
  end

  // State register; a low enable freezes everything, bus included
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      q <= CORE_RESET;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Outputs
  assign o_rdata = q.rdata;
  assign o_eq_ctl.ctle_adapt_en = q.ctle_en;
  assign o_eq_ctl.dfe_adapt_en = q.dfe_en;
  assign o_eq_ctl.merit = q.merit;
  // Only enabled sources reach the pin
  assign o_irq = |(q.status & irq_mask);

endmodule

// ===== hw/rta_eye_check.sv
// Compares one eye opening against an interrupt level and a minimum.
// Assumes the measurement is held stable while its valid is high.
`timescale 1ns/1ps
module rta_eye_check #(
  parameter int EYE_W = rta_pkg::EYE_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_valid,
  input wire logic [EYE_W-1:0] i_eye,
  input wire logic [rta_pkg::LEVEL_W-1:0] i_irq_level,
  input wire logic [rta_pkg::LEVEL_W-1:0] i_min_level,
  output logic o_below_irq,
  output logic o_meets_min
);

  typedef logic [EYE_W-1:0] rta_eye_t;

  // Latest comparison results
  typedef struct packed {
    logic below;
    logic meets;
  } rta_eye_st_s;

  rta_eye_st_s q;
  rta_eye_st_s d;
  rta_eye_t irq_lim;
  rta_eye_t min_lim;

  // One level step is worth eight counts of opening
  assign irq_lim = rta_eye_t'(i_irq_level) << rta_pkg::EYE_UNIT_SHIFT;
  assign min_lim = rta_eye_t'(i_min_level) << rta_pkg::EYE_UNIT_SHIFT;

  // Results only move on a fresh measurement
  always_comb begin
    d = q;
    if (i_valid) begin
      d.below = i_eye < irq_lim;
      d.meets = i_eye >= min_lim;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_below_irq = q.below;
  assign o_meets_min = q.meets;

endmodule

// ===== hw/rta_pin_sync.sv
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous levels; short glitches are dropped.
`timescale 1ns/1ps
module rta_pin_sync #(
  parameter int W = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  // Stage flops and filtered level
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } rta_sync_st_s;

  rta_sync_st_s q;
  rta_sync_st_s d;

  // Stage one is read only by stage two
  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int b = 0; b < W; b++) begin
      // Change accepted once stages two and three agree
      if (q.s2[b] == q.s3[b]) begin
        d.level[b] = q.s3[b];
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_level = q.level;

endmodule

// ===== hw/rta_pkg.sv
// Shared constants and types for the retimer channel adaptation and
// interrupt configuration slice.
// Assumes an 8-bit register port and one system clock domain.
package rta_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_IRQ_ADAPT_CTRL = 8'h31;
  localparam logic [7:0] ADDR_EYE_IRQ_THR = 8'h32;
  localparam logic [7:0] ADDR_EYE_MIN_DFE = 8'h33;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h3d;
  localparam logic [7:0] ADDR_EYE_IRQ_EN = 8'h3e;
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h3f;

  // Values after reset
  localparam logic [7:0] RST_IRQ_ADAPT_CTRL = 8'h20;
  localparam logic [7:0] RST_EYE_IRQ_THR = 8'h11;
  localparam logic [7:0] RST_EYE_MIN_DFE = 8'h88;
  localparam logic [7:0] RST_EYE_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Fields of the control register
  localparam int BIT_PRBS_EN = 7;
  localparam int MODE_LSB = 5;
  localparam int MERIT_LSB = 3;
  localparam int BIT_LOCK_EN = 1;
  localparam int BIT_SIGDET_EN = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'hfb;

  // Layout shared by status and mask
  localparam int STAT_PRBS = 7;
  localparam int STAT_EYE = 2;
  localparam int STAT_LOCK = 1;
  localparam int STAT_SIGDET = 0;
  localparam logic [7:0] STAT_USED_MASK = 8'h87;
  localparam logic [7:0] EYE_EN_MASK = 8'h04;

  // Threshold nibbles and their scale
  localparam int HORIZ_LSB = 4;
  localparam int VERT_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam int EYE_UNIT_SHIFT = 3;
  localparam int EYE_W = 8;

  // Adaptation sequence select
  typedef enum logic [1:0] {
    ADAPT_NONE,
    ADAPT_CTLE_ONLY,
    ADAPT_CTLE_DFE_CTLE,
    ADAPT_LOCK_DFE_EQ
  } rta_mode_e;

  // Figure of merit handed to the CTLE engine
  typedef enum logic [1:0] {
    MERIT_BOTH,
    MERIT_HORIZ,
    MERIT_VERT,
    MERIT_ALT
  } rta_merit_e;

  // Adaptation sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTLE_FIRST,
    ST_DFE,
    ST_CTLE_FINAL,
    ST_DONE
  } rta_state_e;

  // One eye measurement from the monitor
  typedef struct packed {
    logic [EYE_W-1:0] horiz;
    logic [EYE_W-1:0] vert;
  } rta_eye_s;

  // Controls toward the equalizer engines
  typedef struct packed {
    logic ctle_adapt_en;
    logic dfe_adapt_en;
    rta_merit_e merit;
  } rta_eq_ctl_s;

endpackage

// ===== test/rta_channel_cfg_assertions.sv
// Port-level checks for the channel configuration slice.
// Assumes the top's ports only; shadows written registers itself.
`timescale 1ns/1ps
module rta_channel_cfg_assertions #(
  parameter int EYE_W = rta_pkg::EYE_W
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_cdr_lock,
  input wire logic i_sigdet,
  input wire logic i_prbs_err,
  input wire logic i_eye_valid,
  input wire rta_pkg::rta_eye_s i_eye,
  input wire logic i_alt_merit,
  input wire logic i_adapt_restart,
  input wire logic i_ctle_optimal,
  input wire logic i_dfe_done,
  input wire rta_pkg::rta_eq_ctl_s o_eq_ctl,
  input wire logic o_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] ctl_q; // Shadow of the control register
  logic eye_en_q; // Shadow of the eye interrupt enable
  logic wr_ctl; // Control write at this edge
  logic [1:0] mode;
  rta_pkg::rta_merit_e fom_exp; // Merit the field alone asks for
  assign wr_ctl = i_clk_en && i_wr && i_addr == 8'h31;
  assign mode = ctl_q[6:5];
  assign fom_exp = (ctl_q[4:3] == 2'h1) ? rta_pkg::MERIT_HORIZ :
    (ctl_q[4:3] == 2'h2) ? rta_pkg::MERIT_VERT : rta_pkg::MERIT_BOTH;
  // Shadows follow bus writes so masks need no internal probes
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctl_q <= 8'h20;
      eye_en_q <= 1'b0;
    end else if (i_clk_en && i_wr && i_addr == 8'h31) begin
      ctl_q <= i_wdata;
    end else if (i_clk_en && i_wr && i_addr == 8'h3e) begin
      eye_en_q <= i_wdata[2];
    end
  end
  AST_PRBS_IRQ: assert property (
    i_clk_en && i_prbs_err && ctl_q[7] && !wr_ctl |=> o_irq)
    else $error("prbs error did not raise irq");
  AST_IRQ_GATED: assert property (
    o_irq |-> (ctl_q & 8'h83) != 8'h00 || eye_en_q)
    else $error("irq high with all sources masked");
  AST_LOCK_IRQ: assert property (
    $fell(i_cdr_lock) && ctl_q[1] && !wr_ctl |-> ##[2:8] o_irq)
    else $error("lock loss did not raise irq");
  AST_SIGDET_IRQ: assert property (
    $fell(i_sigdet) && ctl_q[0] && !wr_ctl |-> ##[2:8] o_irq)
    else $error("signal loss did not raise irq");
  AST_MERIT_ALT: assert property (
    i_clk_en && i_alt_merit |=> o_eq_ctl.merit == rta_pkg::MERIT_ALT)
    else $error("alternate merit not selected");
  AST_MERIT_FIELD: assert property (
    i_clk_en && !i_alt_merit |=> o_eq_ctl.merit == $past(fom_exp))
    else $error("merit does not follow its field");
  AST_MODE0_IDLE: assert property (
    (mode == 2'h0) |-> !o_eq_ctl.ctle_adapt_en && !o_eq_ctl.dfe_adapt_en)
    else $error("adaptation running in mode zero");
  AST_EQ_EXCL: assert property (
    !(o_eq_ctl.ctle_adapt_en && o_eq_ctl.dfe_adapt_en))
    else $error("both engines enabled");
  AST_DFE_FROM_CTLE: assert property (
    $rose(o_eq_ctl.dfe_adapt_en) |-> $past(o_eq_ctl.ctle_adapt_en))
    else $error("dfe started without ctle before it");
  AST_CTLE_AFTER_DFE: assert property (
    o_eq_ctl.dfe_adapt_en && i_dfe_done && mode[1] && !wr_ctl
    |=> o_eq_ctl.ctle_adapt_en)
    else $error("ctle did not follow dfe");
  COV_DFE: cover property ($rose(o_eq_ctl.dfe_adapt_en));
  COV_IRQ: cover property ($rose(o_irq));
  COV_ALT: cover property (i_alt_merit);
endmodule
bind rta_channel_cfg rta_channel_cfg_assertions #(.EYE_W(EYE_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_cdr_lock(i_cdr_lock), .i_sigdet(i_sigdet),
  .i_prbs_err(i_prbs_err), .i_eye_valid(i_eye_valid), .i_eye(i_eye),
  .i_alt_merit(i_alt_merit), .i_adapt_restart(i_adapt_restart),
  .i_ctle_optimal(i_ctle_optimal), .i_dfe_done(i_dfe_done),
  .o_eq_ctl(o_eq_ctl), .o_irq(o_irq));

// ===== test/rta_engine_model.sv
// Stand-in for the CTLE and DFE engines behind the slice.
// Assumes the slice's engine enables; answers after LAT plus one enabled cycles.
`timescale 1ns/1ps
module rta_engine_model #(
  parameter int LAT = 3 // One less than the enabled cycles before an engine reports
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire rta_pkg::rta_eq_ctl_s i_eq_ctl,
  output logic o_ctle_optimal,
  output logic o_dfe_done
);
  int cnt; // Cycles spent with an engine enabled
  // One-cycle reports; counting restarts whenever both engines idle
  always_ff @(posedge i_sys_clk) begin
    o_ctle_optimal <= 1'b0;
    o_dfe_done <= 1'b0;
    if (i_sys_rst || !(i_eq_ctl.ctle_adapt_en || i_eq_ctl.dfe_adapt_en)) begin
      cnt <= 0;
    end else if (cnt == LAT) begin
      cnt <= 0;
      o_ctle_optimal <= i_eq_ctl.ctle_adapt_en;
      o_dfe_done <= i_eq_ctl.dfe_adapt_en;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the channel configuration slice.
// Assumes the slice's register port and the engine stand-in.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d; // Last value read
  logic lock = 1'b1;
  logic sigdet = 1'b1;
  logic prbs = 1'b0;
  logic alt = 1'b0;
  logic ce = 1'b1; // Clock enable of the slice
  logic restart = 1'b0; // Adaptation restart pulse
  logic irq, opt, dfe_done;
  int dfe_cnt = 0; // Cycles with the DFE enabled
  int dfe_mark; // Count at the start of a run
  rta_pkg::rta_eye_s eye = 16'h4040;
  rta_pkg::rta_eq_ctl_s eq;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  rta_channel_cfg uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_cdr_lock(lock), .i_sigdet(sigdet), .i_prbs_err(prbs),
    .i_eye_valid(1'b1), .i_eye(eye), .i_alt_merit(alt),
    .i_adapt_restart(restart), .i_ctle_optimal(opt), .i_dfe_done(dfe_done),
    .o_eq_ctl(eq), .o_irq(irq));
  rta_engine_model eng (.i_sys_clk(clk), .i_sys_rst(rst), .i_eq_ctl(eq),
    .o_ctle_optimal(opt), .o_dfe_done(dfe_done));
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cycle ceiling well above the few hundred the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (eq.dfe_adapt_en) dfe_cnt <= dfe_cnt + 1;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    // Step off the edge so outputs launched by the write have settled
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_get(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    rd_get(a);
    chk(d, exp);
  endtask
  // Polls live status until the sequencer reports done
  task automatic wait_done();
    for (int i = 0; i < 60; i++) begin
      rd_get(8'h3f);
      if (d[7]) break;
    end
    chk(d & 8'hf0, 8'hc0);
  endtask
  initial begin
    ticks(16);
    rst <= 1'b0;
    rd_reg(8'h31, 8'h20);
    rd_reg(8'h32, 8'h11);
    rd_reg(8'h33, 8'h88);
    rd_reg(8'h3d, 8'h00);
    wr_reg(8'h40, 8'hff);
    rd_reg(8'h40, 8'h00);
    wr_reg(8'h32, 8'h85);
    rd_reg(8'h32, 8'h85);
    wr_reg(8'h33, 8'hff);
    rd_reg(8'h33, 8'hff);
    wr_reg(8'h31, 8'h07);
    rd_reg(8'h31, 8'h03);
    // Signal loss, then lock loss, each sticky until cleared
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) {lock, sigdet} <= k ? 2'b01 : 2'b10;
      ticks(10);
      rd_reg(8'h3d, 8'h01 << k);
      chk({7'h0, irq}, 8'h01);
      wr_reg(8'h3d, 8'h01 << k);
      @(posedge clk) {lock, sigdet} <= 2'b11;
      ticks(10);
    end
    rd_reg(8'h3d, 8'h00);
    // Masked error still sets status; enabling it then raises irq
    wr_reg(8'h31, 8'h00);
    @(posedge clk) prbs <= 1'b1; // PRBS checker stand-in
    @(posedge clk) prbs <= 1'b0;
    rd_reg(8'h3d, 8'h80);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'h31, 8'h80);
    chk({7'h0, irq}, 8'h01);
    wr_reg(8'h3d, 8'h80);
    chk({7'h0, irq}, 8'h00);
    // Error while enabled raises the line at once
    @(posedge clk) prbs <= 1'b1;
    @(posedge clk) prbs <= 1'b0;
    rd_reg(8'h3d, 8'h80);
    chk({7'h0, irq}, 8'h01);
    wr_reg(8'h3d, 8'h80);
    // Eye levels 2 and 1 give 16 and 8 counts; at the level is no event
    wr_reg(8'h32, 8'h21);
    wr_reg(8'h3e, 8'h04);
    rd_reg(8'h3e, 8'h04);
    @(posedge clk) eye <= 16'h1008;
    ticks(4);
    rd_reg(8'h3d, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) eye <= k ? 16'h1007 : 16'h0f08;
      ticks(4);
      rd_reg(8'h3d, 8'h04);
      chk({7'h0, irq}, 8'h01);
      wr_reg(8'h3d, 8'h04);
      @(posedge clk) eye <= 16'h1008;
      ticks(4);
    end
    // Merit codes and the alternate override, all in mode zero
    // A low clock enable freezes the slice, bus strobes included
    @(posedge clk) ce <= 1'b0;
    wr_reg(8'h32, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rd_reg(8'h32, 8'h21);
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h31, 8'h08 * k);
      ticks(2);
      chk({6'h0, eq.merit}, (k == 3) ? 8'h00 : 8'(k));
    end
    @(posedge clk) alt <= 1'b1;
    ticks(2);
    chk({6'h0, eq.merit}, 8'h03);
    alt <= 1'b0;
    // DFE power assumed up outside this slice
    for (int k = 1; k < 3; k++) begin
      dfe_mark = dfe_cnt;
      wr_reg(8'h31, 8'h20 * k);
      wait_done();
      chk({7'h0, dfe_cnt != dfe_mark}, 8'(k - 1));
    end
    // Mode three holds the CTLE until the eye meets the minimum
    dfe_mark = dfe_cnt;
    wr_reg(8'h31, 8'h60);
    ticks(30);
    rd_get(8'h3f);
    chk(d & 8'hf0, 8'h10);
    chk({7'h0, dfe_cnt != dfe_mark}, 8'h00);
    wr_reg(8'h33, 8'h21);
    wait_done();
    chk({7'h0, dfe_cnt != dfe_mark}, 8'h01);
    // A restart pulse from done runs the whole sequence again
    dfe_mark = dfe_cnt;
    @(posedge clk) restart <= 1'b1;
    @(posedge clk) restart <= 1'b0;
    wait_done();
    chk({7'h0, dfe_cnt != dfe_mark}, 8'h01);
    tally_and_finish();
  end
endmodule
